/* File: rtl/gcrb_map.svh */
// offsets, field positions, reset values and frame figures of the control bank
`ifndef GCRB_MAP_SVH
`define GCRB_MAP_SVH

// ============================================================
// register offsets (5-bit frame address)
`define GCRB_OFS_GC1       5'h00
`define GCRB_OFS_GC2       5'h01
`define GCRB_OFS_CCP       5'h05
`define GCRB_OFS_DLY_FIRST 5'h0e
`define GCRB_OFS_DLY_LAST  5'h10

// ============================================================
// reset values
`define GCRB_GC1_RST       16'h0026
`define GCRB_DLY_RST       16'h0a0a
`define GCRB_CCP_RST       16'h4924

// ============================================================
// field positions of general_control_one
`define GCRB_BIT_S2_DIR    15
`define GCRB_BIT_BANK      9
`define GCRB_BIT_OV_TH     8
`define GCRB_BIT_UNLOCK    7
`define GCRB_BIT_RSV_HI    6
`define GCRB_BIT_FMOD      5
`define GCRB_BIT_RSV_LO    4
`define GCRB_BIT_TRIG      0
`define GCRB_GC1_WMASK     16'hffaf

// field position of the disable bit in general_control_two
`define GCRB_BIT_WD_DIS    9

// ============================================================
// frame figures
`define GCRB_FRAME_BITS    5'd24
`define GCRB_CNT_MAX       5'h1f

`endif

/* File: rtl/gcrb_pkg.sv */
// types shared by the general control register bank
package gcrb_pkg;

    // ============================================================
    // one serial frame, msb first on the wire
    typedef struct packed {
        logic        wr;      // one: write, zero: read only
        logic [4:0]  addr;    // register offset
        logic [1:0]  spare;   // ignored
        logic [15:0] data;    // write data
    } gcrb_frame_s;

    // ============================================================
    // decoded view of general_control_one
    typedef struct packed {
        logic       sense2_direction;
        logic [1:0] sense2_gain;
        logic       sense1_direction;
        logic [1:0] sense1_gain;
        logic       bank_select;
        logic       overvoltage_threshold_select;
        logic       unlock;
        logic       freq_modulation_enable;
        logic       adapt_step_size;
        logic       overcurrent_shutdown_enable;
        logic       watchdog_period;
        logic       watchdog_trigger;
    } gcrb_cfg_s;

endpackage

/* File: rtl/gcrb_bank.sv */
// general control register bank behind a 24-bit serial port
//
// Overview of operation
// R1: control word one resets to 0x0026
// R2: bit 15 picks sense two direction
// R3: bits 14:13 set sense two gain
// R4: bit 12 picks sense one direction
// R5: bits 11:10 set sense one gain
// R6: bit 9 selects which bank aliases
// R7: bit 8 picks overvoltage threshold
// R8: bit 7 unlocks watchdog disable next frame
// R9: reserved bits 6 and 4 read zero
// R10: bit 5 enables frequency modulation
// R11: bit 3 sets adaptation step size
// R12: bit 2 enables overcurrent shutdown
// R13: trigger bit resets zero, host toggles it
// R14: write keeping trigger unchanged forces fail safe
// R15: three delay registers 0x0e-0x10, reset 0x0a0a
// R16: disable needs prior unlock; clear acts at once
// R17: offset 0x05 follows the bank bit
// R18: reserved writes ignored, update at frame end
`timescale 1ns/10ps
`include "gcrb_map.svh"

module gcrb_bank (
    // clock and reset
    input  wire logic                ref_clk_i,
    input  wire logic                rst_i,
    // serial pins
    input  wire logic                sclk_i,
    input  wire logic                csn_i,
    input  wire logic                sdi_i,
    output logic                     sdo_o,
    output logic                     sdo_oe_o,
    // configuration to the driver core
    output gcrb_pkg::gcrb_cfg_s      cfg_o,
    output logic [2:0][15:0]         pwm_delay_o,
    output logic [15:0]              active_ccp_o,
    output logic [15:0]              freewheel_ccp_o,
    // watchdog state
    output logic                     watchdog_enable_o,
    output logic                     fail_safe_o
);

    // ============================================================
    // pin synchronisers; stage one feeds stage two only
    logic [2:0]        sclk_q;        // [0] raw, [1] safe, [2] edge history
    logic [2:0]        csn_q;         // same layout for chip select
    logic [1:0]        sdi_q;         // [1] safe sample
    logic              sclk_rise;     // sampling edge
    logic              sclk_fall;     // shifting edge
    logic              csn_fall;      // frame start
    logic              csn_rise;      // frame end
    logic              sel;           // frame in progress

    // a slow link only: sclk must stay well below a quarter of ref_clk
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            sclk_q <= 3'h0;
            csn_q  <= 3'h7;
            sdi_q  <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], sclk_i};
            csn_q  <= {csn_q[1:0], csn_i};
            sdi_q  <= {sdi_q[0], sdi_i};
        end
    end

    assign sclk_rise = sclk_q[1] & ~sclk_q[2];
    assign sclk_fall = ~sclk_q[1] & sclk_q[2];
    assign csn_fall  = ~csn_q[1] & csn_q[2];
    assign csn_rise  = csn_q[1] & ~csn_q[2];
    assign sel       = ~csn_q[1];

    // ============================================================
    // frame receiver
    logic [4:0]            bit_cnt_q;     // edges seen, saturating
    logic [23:0]           rx_q;          // incoming bits
    logic                  done_q;        // one-cycle valid frame pulse
    gcrb_pkg::gcrb_frame_s frm;           // view of the last frame

    assign frm = rx_q;

    // count sampling edges; a long frame saturates and is dropped
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            bit_cnt_q <= 5'h00;
        end else if (csn_fall) begin
            bit_cnt_q <= 5'h00;
        end else if (sel && sclk_rise && bit_cnt_q != `GCRB_CNT_MAX) begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
        end
    end

    // shift in msb first while selected
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            rx_q <= 24'h000000;
        end else if (sel && sclk_rise) begin
            rx_q <= {rx_q[22:0], sdi_q[1]};
        end
    end

    // only an exact 24-edge frame counts
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            done_q <= 1'b0;
        end else begin
            done_q <= csn_rise && (bit_cnt_q == `GCRB_FRAME_BITS); // R18
        end
    end

    // ============================================================
    // register storage
    logic [15:0]       gc1_q;         // general_control_one
    logic              wd_dis_q;      // watchdog_disable
    logic              unlock_arm_q;  // previous frame set unlock
    logic              fail_q;        // fail safe, held until reset
    logic [15:0]       dly_q [3];     // pwm switch delays
    logic [15:0]       ccp_act_q;     // active_crosscurrent_blanking
    logic [15:0]       ccp_fw_q;      // freewheel_crosscurrent_blanking
    logic              wr_gc1;        // valid write to word one
    logic              wr_gc2;        // valid write to word two
    logic              bank;          // alias select

    assign wr_gc1 = done_q && frm.wr && frm.addr == `GCRB_OFS_GC1;
    assign wr_gc2 = done_q && frm.wr && frm.addr == `GCRB_OFS_GC2;
    assign bank   = gc1_q[`GCRB_BIT_BANK];

    // word one; the mask keeps reserved bits at zero
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            gc1_q <= `GCRB_GC1_RST; // R1 R13
        end else if (wr_gc1) begin
            gc1_q <= frm.data & `GCRB_GC1_WMASK; // R9 R18
        end
    end

    // a write that leaves the trigger alone trips fail safe
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fail_q <= 1'b0;
        end else if (wr_gc1 && frm.data[`GCRB_BIT_TRIG] == gc1_q[`GCRB_BIT_TRIG]) begin
            fail_q <= 1'b1; // R14
        end
    end

    // unlock is good for the single next frame only
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            unlock_arm_q <= 1'b0;
        end else if (done_q) begin
            unlock_arm_q <= wr_gc1 && frm.data[`GCRB_BIT_UNLOCK]; // R8
        end
    end

    // disable: set needs the armed unlock, clear always wins
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            wd_dis_q <= 1'b0;
        end else if (wr_gc2) begin
            if (!frm.data[`GCRB_BIT_WD_DIS]) begin
                wd_dis_q <= 1'b0; // R16
            end else if (unlock_arm_q) begin
                wd_dis_q <= 1'b1; // R8 R16
            end
        end
    end

    // delay words live in both banks at the same offsets
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 3; i++) begin
                dly_q[i] <= `GCRB_DLY_RST; // R15
            end
        end else if (done_q && frm.wr) begin
            for (int i = 0; i < 3; i++) begin
                if (frm.addr == `GCRB_OFS_DLY_FIRST + 5'(i)) begin
                    dly_q[i] <= frm.data; // R15
                end
            end
        end
    end

    // aliased word at 0x05: the bank bit picks the target
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ccp_act_q <= `GCRB_CCP_RST;
            ccp_fw_q  <= `GCRB_CCP_RST;
        end else if (done_q && frm.wr && frm.addr == `GCRB_OFS_CCP) begin
            if (bank) begin
                ccp_fw_q <= frm.data; // R6 R17
            end else begin
                ccp_act_q <= frm.data; // R6 R17
            end
        end
    end

    // ============================================================
    // read path; unmapped offsets answer zero
    logic [15:0]       rd_word;       // word at the frame's offset

    always_comb begin
        rd_word = 16'h0000;
        unique case (frm.addr)
            `GCRB_OFS_GC1: rd_word = gc1_q;
            `GCRB_OFS_GC2: rd_word = {6'h00, wd_dis_q, 9'h000};
            `GCRB_OFS_CCP: rd_word = bank ? ccp_fw_q : ccp_act_q; // R17
            5'h0e:         rd_word = dly_q[0];
            5'h0f:         rd_word = dly_q[1];
            `GCRB_OFS_DLY_LAST: rd_word = dly_q[2];
            default:       rd_word = 16'h0000;
        endcase
    end

    // ============================================================
    // reply path: the next frame returns this frame's read word
    logic [23:0]       resp_q;        // reply staged for next frame
    logic [23:0]       tx_q;          // outgoing shifter

    // the read happens before this frame's own write lands
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            resp_q <= 24'h000000;
        end else if (done_q) begin
            resp_q <= {8'h00, rd_word};
        end
    end

    // load at select, shift on falling sclk
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tx_q <= 24'h000000;
        end else if (csn_fall) begin
            tx_q <= resp_q;
        end else if (sel && sclk_fall) begin
            tx_q <= {tx_q[22:0], 1'b0};
        end
    end

    assign sdo_o    = tx_q[23];
    assign sdo_oe_o = sel;

    // ============================================================
    // configuration outputs, all straight from flops
    assign cfg_o             = {gc1_q[15:7], gc1_q[5], gc1_q[3:0]}; // R2 R3 R4 R5 R6 R7 R10 R11 R12
    assign pwm_delay_o       = {dly_q[2], dly_q[1], dly_q[0]};
    assign active_ccp_o      = ccp_act_q;
    assign freewheel_ccp_o   = ccp_fw_q;
    assign watchdog_enable_o = ~wd_dis_q; // R16
    assign fail_safe_o       = fail_q;

    // ============================================================
    // checks
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    property p_reset_word;
        $past(rst_i) |-> gc1_q == 16'h0026 && !fail_q && !wd_dis_q;
    endproperty
    a_reset_word: assert property (p_reset_word) else $error("word one reset wrong"); // R1 R13

    property p_reserved_zero;
        !gc1_q[`GCRB_BIT_RSV_HI] && !gc1_q[`GCRB_BIT_RSV_LO];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // R9

    property p_fields_map;
        cfg_o.sense2_gain == gc1_q[14:13] && cfg_o.sense1_gain == gc1_q[11:10]
            && cfg_o.sense2_direction == gc1_q[15] && cfg_o.sense1_direction == gc1_q[12]
            && cfg_o.bank_select == gc1_q[9] && cfg_o.overvoltage_threshold_select == gc1_q[8]
            && cfg_o.freq_modulation_enable == gc1_q[5] && cfg_o.adapt_step_size == gc1_q[3]
            && cfg_o.overcurrent_shutdown_enable == gc1_q[2];
    endproperty
    a_fields_map: assert property (p_fields_map) else $error("field map wrong"); // R3

    property p_fail_trip;
        wr_gc1 && frm.data[0] == gc1_q[0] |=> fail_safe_o [*4];
    endproperty
    a_fail_trip: assert property (p_fail_trip) else $error("fail safe not held"); // R14

    property p_no_false_trip;
        !fail_safe_o && !(wr_gc1 && frm.data[0] == gc1_q[0]) |=> !fail_safe_o;
    endproperty
    a_no_false_trip: assert property (p_no_false_trip) else $error("spurious fail safe"); // R14

    property p_locked;
        wr_gc2 && !unlock_arm_q && !wd_dis_q |=> watchdog_enable_o;
    endproperty
    a_locked: assert property (p_locked) else $error("disable without unlock"); // R8

    property p_unlocked;
        wr_gc2 && unlock_arm_q && frm.data[9] |=> !watchdog_enable_o;
    endproperty
    a_unlocked: assert property (p_unlocked) else $error("unlocked disable lost"); // R16

    property p_reenable;
        wr_gc2 && !frm.data[9] |=> watchdog_enable_o;
    endproperty
    a_reenable: assert property (p_reenable) else $error("clear did not re-enable"); // R16

    property p_frame_end_only;
        !done_q |=> $stable(gc1_q) && $stable(ccp_act_q) && $stable(ccp_fw_q);
    endproperty
    a_frame_end_only: assert property (p_frame_end_only) else $error("update outside frame end"); // R18

    property p_alias;
        done_q && frm.wr && frm.addr == 5'h05 && !bank |=> ccp_act_q == $past(frm.data) && $stable(ccp_fw_q);
    endproperty
    a_alias: assert property (p_alias) else $error("bank alias wrong"); // R17

    property p_delay_reset;
        $past(rst_i) |-> dly_q[0] == 16'h0a0a && dly_q[1] == 16'h0a0a && dly_q[2] == 16'h0a0a;
    endproperty
    a_delay_reset: assert property (p_delay_reset) else $error("delay reset wrong"); // R15

    property p_short_frame_dropped;
        csn_rise && bit_cnt_q != `GCRB_FRAME_BITS |=> !done_q;
    endproperty
    a_short_frame_dropped: assert property (p_short_frame_dropped) else $error("bad frame accepted"); // R18

    property p_unlock_single;
        done_q && !(wr_gc1 && frm.data[`GCRB_BIT_UNLOCK]) |=> !unlock_arm_q;
    endproperty
    a_unlock_single: assert property (p_unlock_single) else $error("unlock outlived its frame"); // R8

    property p_fail_sticky;
        fail_safe_o |=> fail_safe_o;
    endproperty
    a_fail_sticky: assert property (p_fail_sticky) else $error("fail safe dropped"); // R14

    property p_delay_write;
        done_q && frm.wr && frm.addr == `GCRB_OFS_DLY_FIRST |=> dly_q[0] == $past(frm.data);
    endproperty
    a_delay_write: assert property (p_delay_write) else $error("delay write lost"); // R15

    property p_trigger_follows;
        wr_gc1 |=> gc1_q[`GCRB_BIT_TRIG] == $past(frm.data[`GCRB_BIT_TRIG]);
    endproperty
    a_trigger_follows: assert property (p_trigger_follows) else $error("trigger not stored"); // R13

    property p_alias_fw;
        done_q && frm.wr && frm.addr == `GCRB_OFS_CCP && bank |=> ccp_fw_q == $past(frm.data) && $stable(ccp_act_q);
    endproperty
    a_alias_fw: assert property (p_alias_fw) else $error("free-wheel alias wrong"); // R6

endmodule

/* File: verification/gcrb_host.sv */
// host side serial master model that frames requests for the control bank
`timescale 1ns/10ps

module gcrb_host (
    // clock
    input  wire logic ref_clk_i,
    // serial pins towards the bank
    output logic      sclk_o,
    output logic      csn_o,
    output logic      sdi_o,
    input  wire logic sdo_i
);
    // ============================================================
    // idle levels: clock low and deselected between frames
    initial begin
        sclk_o = 1'b0;
        csn_o  = 1'b1;
        sdi_o  = 1'b0;
    end

    // ============================================================
    // wait a number of reference cycles
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask

    // one frame, msb first; six cycles per half clock keeps us above the sync margin
    // a count other than 24 makes a frame that the bank must drop
    task automatic xfer(input logic [23:0] frm, input int nbits, output logic [23:0] rpl);
        rpl = 24'h000000;
        tick(1);
        csn_o <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi_o <= frm[23 - i];
            tick(6);
            // reply bit has been stable since the last falling clock
            rpl = {rpl[22:0], sdo_i};
            sclk_o <= 1'b1;
            tick(6);
            sclk_o <= 1'b0;
        end
        tick(6);
        csn_o <= 1'b1;
        // released data line must not keep its last value
        sdi_o <= ~sdi_o;
        tick(10);
    endtask
endmodule

/* File: verification/tb.sv */
// self-checking bench for the general control register bank
`timescale 1ns/10ps

`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
    $display("wrong value %s expected %h seen %h", nm, exp, got); end end

module tb;
    // ============================================================
    // signals
    logic                ref_clk_i;   // 20 MHz reference
    logic                rst_i;       // synchronous reset
    logic                sclk;        // serial clock from host
    logic                csn;         // select from host
    logic                sdi;         // data towards bank
    logic                sdo;         // data from bank
    logic                sdo_oe;      // bank drives sdo
    gcrb_pkg::gcrb_cfg_s cfg;         // decoded word one
    logic [2:0][15:0]    dly;         // delay words
    logic [15:0]         act_ccp;     // active alias of 0x05
    logic [15:0]         fw_ccp;      // free-wheel alias of 0x05
    logic                wd_en;       // watchdog running
    logic                fail_safe;   // sticky fault
    logic [23:0]         r;           // last reply
    logic                trig;        // trigger value last written
    logic [15:0]         d;           // scratch word
    int                  fail_count;
    int                  n_compared;
    int                  cyc;

    // ============================================================
    // clock
    initial begin
        ref_clk_i = 1'b0;
        forever #25 ref_clk_i = ~ref_clk_i;
    end

    gcrb_bank dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sclk_i(sclk), .csn_i(csn), .sdi_i(sdi),
                   .sdo_o(sdo), .sdo_oe_o(sdo_oe), .cfg_o(cfg), .pwm_delay_o(dly), .active_ccp_o(act_ccp),
                   .freewheel_ccp_o(fw_ccp), .watchdog_enable_o(wd_en), .fail_safe_o(fail_safe));

    gcrb_host host (.ref_clk_i(ref_clk_i), .sclk_o(sclk), .csn_o(csn), .sdi_o(sdi), .sdo_i(sdo));

    // ============================================================
    // access tasks
    task automatic wr(input logic [4:0] a, input logic [15:0] v);
        host.xfer({1'b1, a, 2'b00, v}, 24, r);
    endtask

    // read needs a second frame, since the reply trails by one
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        host.xfer({1'b0, a, 18'h00000}, 24, r);
        host.xfer(24'h000000, 24, r);
        `CHK("reply", {8'h00, exp}, r)
    endtask

    // write word one with the trigger inverted, as the host must
    task automatic wgc1(input logic [15:0] v);
        trig = ~trig;
        d = {v[15:1], trig};
        wr(5'h00, d);
        d = d & 16'hffaf;
        `CHK("cfg", gcrb_pkg::gcrb_cfg_s'({d[15:7], d[5], d[3:0]}), cfg)
        `CHK("fail_safe", 1'b0, fail_safe)
    endtask

    // ============================================================
    // verdict, reached from the sequence or from the timeout
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // a run is about 48 frames of ~305 cycles; this ceiling leaves wide margin
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 50000) begin
            fail_count++;
            conclude();
        end
    end

    // ============================================================
    // main sequence
    initial begin
        rst_i = 1'b1;
        trig = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        // reset state
        `CHK("cfg", gcrb_pkg::gcrb_cfg_s'(14'h0016), cfg)
        `CHK("sdo_oe", 1'b0, sdo_oe)
        for (int i = 0; i < 3; i++) `CHK("delay", 16'h0a0a, dly[i])
        `CHK("act_ccp", 16'h4924, act_ccp)
        `CHK("fw_ccp", 16'h4924, fw_ccp)
        `CHK("wd_en", 1'b1, wd_en)
        `CHK("fail_safe", 1'b0, fail_safe)
        rd(5'h00, 16'h0026);
        for (int i = 0; i < 3; i++) rd(5'h0e + i[4:0], 16'h0a0a);
        // short frame must change nothing
        host.xfer({1'b1, 5'h0e, 18'h01111}, 23, r);
        rd(5'h0e, 16'h0a0a);
        // every gain code and both levels of the single-bit fields except bank and unlock, reserved bits written high
        for (int k = 0; k < 4; k++) begin
            d = {k[0], k[1:0], ~k[0], ~k[1:0], 1'b0, k[0], 1'b0, 1'b1, k[1], 1'b1, k[0], k[1], k[0], 1'b0};
            wgc1(d);
            rd(5'h00, {d[15:1], trig} & 16'hffaf);
        end
        // disable needs unlock in the frame just before
        wgc1(16'h0080);
        wr(5'h01, 16'h0200);
        `CHK("wd_en", 1'b0, wd_en)
        rd(5'h01, 16'h0200);
        wr(5'h01, 16'h0000);
        `CHK("wd_en", 1'b1, wd_en)
        wr(5'h01, 16'h0200);
        `CHK("wd_en", 1'b1, wd_en)
        // bank select steers offset 0x05
        wgc1(16'h0000);
        wr(5'h05, 16'h1234);
        `CHK("act_ccp", 16'h1234, act_ccp)
        `CHK("fw_ccp", 16'h4924, fw_ccp)
        wgc1(16'h0200);
        wr(5'h05, 16'h5678);
        `CHK("fw_ccp", 16'h5678, fw_ccp)
        `CHK("act_ccp", 16'h1234, act_ccp)
        rd(5'h05, 16'h5678);
        // delay words, written back to back, then read back in the same bank
        for (int i = 0; i < 3; i++) wr(5'h0e + i[4:0], 16'h0b00 + i[15:0]);
        for (int i = 0; i < 3; i++) `CHK("delay", 16'h0b00 + i[15:0], dly[i])
        for (int i = 0; i < 3; i++) rd(5'h0e + i[4:0], 16'h0b00 + i[15:0]);
        // unmapped offset
        wr(5'h1f, 16'hffff);
        rd(5'h1f, 16'h0000);
        // a write that keeps the trigger forces fail safe
        wr(5'h00, {15'h0000, trig});
        `CHK("fail_safe", 1'b1, fail_safe)
        conclude();
    end
endmodule
